//--- pcg_peripheral_clock_gating.sv
`timescale 1ns/1ps
// Operation
// - One stop bit per peripheral address space
// - High bits 11,10 stop flash, CAN
// - High bits 9,8 stop PWM, timer
// - High bit 7 stops converter clock
// - High bits 4,3 stop interval timers
// - High bits 1,0 stop edge port, I/O
// - High register at 0x0C, resets zero
// - Low register at 0x18, resets 0x8
// - Set at 0x21, clear at 0x22
// - Direct writes update gating registers
// - Bus controller, system control never gated
// - Low-power control at 0x110007, resets 0x2
// - Low-power IRQ control at 0x12, zero
// - Run, wait, doze, stop modes selected
// - Clock output switchable by software
// - Unassigned offsets, bits have no function
// - Low bits 17,4 stop IRQ, DMA
// - IRQ control bit 7 enables stop
module pcg_peripheral_clock_gating (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [23:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic [31:0] gate_high,
    output logic [31:0] gate_low,
    output logic bus_ctrl_clock_stop,
    output logic sys_ctrl_clock_stop,
    output logic stop_mode_enable,
    output logic [2:0] exit_irq_level,
    output pcg_pkg::pcg_mode_t lp_mode,
    output logic external_clock_output_off
);
    import pcg_pkg::*;

    typedef struct packed {
        logic [31:0] high;
        logic [31:0] low;
        logic [7:0] lpc;
        logic [7:0] lpic;
        logic [31:0] rdata;
    } pcg_state_t;

    pcg_state_t st_reg, st_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Applies a set or clear byte to one register; out-of-range selects do nothing
    function automatic logic [31:0] bit_op(input logic [31:0] cur, input logic [7:0] sel,
                                           input logic [7:0] base, input logic set);
        logic [31:0] one;
        logic [7:0] idx;
        one = 32'h0;
        idx = sel - base;
        if (sel >= base && idx < 8'h20) begin
            one[idx[4:0]] = 1'b1;
        end
        bit_op = set ? (cur | one) : (cur & ~one);
    endfunction

    always_comb begin
        st_next = st_reg;
        if (reg_wr) begin
            case (reg_addr)
                OFS_GATE_HIGH: st_next.high = reg_wdata & MASK_GATE_HIGH;
                OFS_GATE_LOW: st_next.low = (reg_wdata & MASK_GATE_LOW) | RST_GATE_LOW;
                OFS_LP_CTRL: st_next.lpc = reg_wdata[7:0];
                OFS_LP_IRQ_CTRL: st_next.lpic = reg_wdata[7:0] & MASK_LP_IRQ_CTRL;
                OFS_GATE_SET: begin
                    if (reg_wdata[7:0] >= SEL_ALL) begin
                        st_next.high = MASK_GATE_HIGH;
                        st_next.low = MASK_GATE_LOW | RST_GATE_LOW;
                    end else begin
                        st_next.high = bit_op(st_reg.high, reg_wdata[7:0], 8'h00, 1'b1)
                            & MASK_GATE_HIGH;
                        st_next.low = bit_op(st_reg.low, reg_wdata[7:0], SEL_LOW_BASE, 1'b1)
                            & (MASK_GATE_LOW | RST_GATE_LOW);
                    end
                end
                OFS_GATE_CLEAR: begin
                    if (reg_wdata[7:0] >= SEL_ALL) begin
                        st_next.high = 32'h0;
                        st_next.low = RST_GATE_LOW;
                    end else begin
                        st_next.high = bit_op(st_reg.high, reg_wdata[7:0], 8'h00, 1'b0);
                        st_next.low = bit_op(st_reg.low, reg_wdata[7:0], SEL_LOW_BASE, 1'b0)
                            | RST_GATE_LOW;
                    end
                end
                default: ;
            endcase
        end
        st_next.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_GATE_HIGH: st_next.rdata = st_reg.high;
                OFS_GATE_LOW: st_next.rdata = st_reg.low;
                OFS_LP_CTRL: st_next.rdata = {24'h0, st_reg.lpc};
                OFS_LP_IRQ_CTRL: st_next.rdata = {24'h0, st_reg.lpic};
                default: st_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.high <= RST_GATE_HIGH;
            st_reg.low <= RST_GATE_LOW;
            st_reg.lpc <= RST_LP_CTRL;
            st_reg.lpic <= RST_LP_IRQ_CTRL;
            st_reg.rdata <= 32'h0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // Outputs are the state flip-flops themselves
    assign reg_rdata = st_reg.rdata;
    assign gate_high = st_reg.high;
    assign gate_low = st_reg.low;
    // Tied off: the bus and system control clocks must never be gated
    assign bus_ctrl_clock_stop = 1'b0;
    assign sys_ctrl_clock_stop = 1'b0;
    assign stop_mode_enable = st_reg.lpic[BIT_STOP_EN];
    assign exit_irq_level = st_reg.lpic[6:4];
    assign lp_mode = pcg_mode_t'(st_reg.lpc[LPM_LSB +: 2]);
    // Clock-out disable lives in bit 0 of the low-power control byte
    assign external_clock_output_off = st_reg.lpc[0];

    chk_high_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (gate_high & ~MASK_GATE_HIGH) == 32'h0) else $error("reserved high bit set");
    chk_low_bit3_set: assert property (@(posedge clock) disable iff (!rst_n)
        gate_low[3]) else $error("low bit 3 not set");
    chk_fixed_clocks: assert property (@(posedge clock) disable iff (!rst_n)
        !bus_ctrl_clock_stop && !sys_ctrl_clock_stop) else $error("fixed clock stopped");
    chk_direct_write: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == OFS_GATE_HIGH |=>
        gate_high == ($past(reg_wdata) & MASK_GATE_HIGH)) else $error("high write lost");
    chk_set_one_bit: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == OFS_GATE_SET && reg_wdata[7:0] == 8'h07 |=>
        gate_high == ($past(gate_high) | 32'h80)) else $error("set wrong bits");
    chk_clr_one_bit: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == OFS_GATE_CLEAR && reg_wdata[7:0] == 8'h31 |=>
        gate_low == ($past(gate_low) & ~32'h0002_0000)) else $error("clear wrong bits");
    chk_stop_enable: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && reg_wr && reg_addr == OFS_LP_IRQ_CTRL |=>
        stop_mode_enable == $past(reg_wdata[7])) else $error("stop enable wrong");
    chk_freeze: assert property (@(posedge clock) disable iff (!rst_n)
        !clk_en |=> $stable(gate_high) && $stable(gate_low)) else $error("state moved");
    chk_unmapped_read: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && reg_rd && reg_addr == 24'h000013 |=> reg_rdata == 32'h0)
        else $error("unmapped read nonzero");

    // Accepted register write or read at one offset
    sequence s_wr_at(logic [23:0] a);
        clk_en && reg_wr && reg_addr == a;
    endsequence

    sequence s_rd_at(logic [23:0] a);
        clk_en && reg_rd && reg_addr == a;
    endsequence

    chk_low_write: assert property (@(posedge clock) disable iff (!rst_n)
        s_wr_at(OFS_GATE_LOW) |=>
        gate_low == (($past(reg_wdata) & MASK_GATE_LOW) | RST_GATE_LOW))
        else $error("low write lost");
    chk_mode_write: assert property (@(posedge clock) disable iff (!rst_n)
        s_wr_at(OFS_LP_CTRL) |=> 2'(lp_mode) == $past(reg_wdata[7:6]))
        else $error("mode write lost");
    chk_external_clock_output_write: assert property (@(posedge clock) disable iff (!rst_n)
        s_wr_at(OFS_LP_CTRL) |=> external_clock_output_off == $past(reg_wdata[0]))
        else $error("clock out write lost");
    chk_set_all: assert property (@(posedge clock) disable iff (!rst_n)
        s_wr_at(OFS_GATE_SET) ##0 (reg_wdata[7:0] >= SEL_ALL) |=>
        gate_high == MASK_GATE_HIGH && gate_low == (MASK_GATE_LOW | RST_GATE_LOW))
        else $error("set all wrong");
    chk_clear_all: assert property (@(posedge clock) disable iff (!rst_n)
        s_wr_at(OFS_GATE_CLEAR) ##0 (reg_wdata[7:0] >= SEL_ALL) |=>
        gate_high == 32'h0 && gate_low == RST_GATE_LOW)
        else $error("clear all wrong");
    chk_read_high: assert property (@(posedge clock) disable iff (!rst_n)
        s_rd_at(OFS_GATE_HIGH) |=> reg_rdata == $past(gate_high))
        else $error("high read wrong");
    chk_read_lpc: assert property (@(posedge clock) disable iff (!rst_n)
        s_rd_at(OFS_LP_CTRL) |=> reg_rdata == {24'h0, $past(st_reg.lpc)})
        else $error("low power read wrong");
    chk_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not idle");
    chk_irq_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        st_reg.lpic[3:0] == 4'h0) else $error("irq reserved bit set");

    // One set and one clear check per implemented high bit
    for (genvar g = 0; g < 32; g++) begin : gen_bit_chk
        if (MASK_GATE_HIGH[g]) begin : gen_impl
            chk_set_high_bit: assert property (@(posedge clock) disable iff (!rst_n)
                s_wr_at(OFS_GATE_SET) ##0 (reg_wdata[7:0] == 8'(g)) |=> gate_high[g])
                else $error("high bit not set");
            chk_clr_high_bit: assert property (@(posedge clock) disable iff (!rst_n)
                s_wr_at(OFS_GATE_CLEAR) ##0 (reg_wdata[7:0] == 8'(g)) |=> !gate_high[g])
                else $error("high bit not cleared");
        end
    end
endmodule

//--- pcg_pkg.sv
package pcg_pkg;
    localparam logic [23:0] OFS_GATE_HIGH = 24'h00000C;
    localparam logic [23:0] OFS_LP_IRQ_CTRL = 24'h000012;
    localparam logic [23:0] OFS_GATE_LOW = 24'h000018;
    localparam logic [23:0] OFS_GATE_SET = 24'h000021;
    localparam logic [23:0] OFS_GATE_CLEAR = 24'h000022;
    localparam logic [23:0] OFS_LP_CTRL = 24'h110007;
    localparam logic [31:0] RST_GATE_HIGH = 32'h00000000;
    localparam logic [31:0] RST_GATE_LOW = 32'h00000008;
    localparam logic [7:0] RST_LP_CTRL = 8'h02;
    localparam logic [7:0] RST_LP_IRQ_CTRL = 8'h00;
    // Implemented bits; everything else is reserved
    localparam logic [31:0] MASK_GATE_HIGH = 32'h00000F9B;
    localparam logic [31:0] MASK_GATE_LOW = 32'h0003E7FA;
    localparam logic [7:0] MASK_LP_IRQ_CTRL = 8'hF0;
    localparam int BIT_FLASH = 11;
    localparam int BIT_CAN = 10;
    localparam int BIT_PWM = 9;
    localparam int BIT_GP_TIMER = 8;
    localparam int BIT_ADC = 7;
    localparam int BIT_TIMER_ONE = 4;
    localparam int BIT_TIMER_ZERO = 3;
    localparam int BIT_EDGE_PORT = 1;
    localparam int BIT_PORTS = 0;
    localparam int BIT_INTC = 17;
    localparam int BIT_DMA = 4;
    localparam int BIT_STOP_EN = 7;
    // Set/clear byte: 0..31 high register, 32..63 low register
    localparam logic [7:0] SEL_LOW_BASE = 8'h20;
    localparam logic [7:0] SEL_ALL = 8'h40;
    localparam int LPM_LSB = 6;
    typedef enum logic [1:0] {
        PCG_RUN = 2'h0,
        PCG_WAIT = 2'h1,
        PCG_DOZE = 2'h3,
        PCG_STOP = 2'h2
    } pcg_mode_t;
endpackage

//--- peripheral_clock_gating_tb.sv
`timescale 1ns/1ps
module peripheral_clock_gating_tb;
    import pcg_pkg::*;
    logic clock, nrst, clk_en, reg_wr, reg_rd;
    logic [23:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, gate_high, gate_low, eh, el;
    logic bus_ctrl_clock_stop, sys_ctrl_clock_stop, stop_mode_enable, external_clock_output_off;
    logic [2:0] exit_irq_level;
    logic [7:0] ei;
    pcg_mode_t lp_mode;
    int num_errors = 0;
    int checks_done = 0;
    pcg_peripheral_clock_gating DUT (.clock(clock), .nrst(nrst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .gate_high(gate_high), .gate_low(gate_low),
        .bus_ctrl_clock_stop(bus_ctrl_clock_stop), .sys_ctrl_clock_stop(sys_ctrl_clock_stop),
        .stop_mode_enable(stop_mode_enable), .exit_irq_level(exit_irq_level),
        .lp_mode(lp_mode), .external_clock_output_off(external_clock_output_off));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [23:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, "read");
    endtask
    // Set/clear address one 64-bit space: high word below, low word above
    function void model(input logic [23:0] a, input logic [31:0] d);
        logic [63:0] all;
        logic [63:0] sel;
        all = {el, eh};
        sel = (d[7:0] >= SEL_ALL) ? '1 : (64'h1 << d[7:0]);
        case (a)
            OFS_GATE_HIGH: all[31:0] = d & MASK_GATE_HIGH;
            OFS_GATE_LOW: all[63:32] = d & MASK_GATE_LOW;
            OFS_LP_IRQ_CTRL: ei = d[7:0] & MASK_LP_IRQ_CTRL;
            OFS_GATE_SET: all = all | (sel & {MASK_GATE_LOW, MASK_GATE_HIGH});
            OFS_GATE_CLEAR: all = all & ~sel;
            default: ;
        endcase
        eh = all[31:0];
        el = all[63:32] | 32'h8;
    endfunction
    task automatic outs;
        chk(gate_high, eh, "high gating");
        chk(gate_low, el, "low gating");
        chk({31'h0, stop_mode_enable}, {31'h0, ei[BIT_STOP_EN]}, "stop enable");
        chk({29'h0, exit_irq_level}, {29'h0, ei[6:4]}, "exit level");
        chk({30'h0, bus_ctrl_clock_stop, sys_ctrl_clock_stop}, 32'h0, "core stops");
    endtask
    initial begin
        logic [23:0] a;
        logic [31:0] d;
        int bits[11];
        logic [23:0] addrs[5];
        bits = '{BIT_FLASH, BIT_CAN, BIT_PWM, BIT_GP_TIMER, BIT_ADC, BIT_TIMER_ONE,
            BIT_TIMER_ZERO, BIT_EDGE_PORT, BIT_PORTS, 32 + BIT_INTC, 32 + BIT_DMA};
        addrs = '{OFS_GATE_HIGH, OFS_GATE_LOW, OFS_GATE_SET, OFS_GATE_CLEAR, OFS_LP_IRQ_CTRL};
        nrst = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        eh = RST_GATE_HIGH;
        el = RST_GATE_LOW;
        ei = RST_LP_IRQ_CTRL;
        void'($urandom(32'h3e4b0f7a));
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        outs();
        rd(OFS_GATE_HIGH, RST_GATE_HIGH);
        rd(OFS_GATE_LOW, RST_GATE_LOW);
        rd(OFS_LP_CTRL, {24'h0, RST_LP_CTRL});
        rd(OFS_LP_IRQ_CTRL, 32'h0);
        $display("reset test done");
        wr(OFS_GATE_HIGH, 32'hFFFFFFFF);
        model(OFS_GATE_HIGH, 32'hFFFFFFFF);
        rd(OFS_GATE_HIGH, eh);
        foreach (bits[i]) begin
            wr(OFS_GATE_CLEAR, 32'h40);
            model(OFS_GATE_CLEAR, 32'h40);
            wr(OFS_GATE_SET, bits[i]);
            model(OFS_GATE_SET, bits[i]);
            outs();
        end
        wr(OFS_GATE_SET, 32'h31);
        model(OFS_GATE_SET, 32'h31);
        wr(OFS_GATE_CLEAR, 32'h31);
        model(OFS_GATE_CLEAR, 32'h31);
        outs();
        $display("bit map test done");
        for (int i = 0; i < 60; i++) begin
            a = addrs[$urandom_range(0, 4)];
            d = (a == OFS_GATE_SET || a == OFS_GATE_CLEAR) ? $urandom_range(0, 64) : $urandom();
            wr(a, d);
            model(a, d);
            outs();
            rd(OFS_GATE_HIGH, eh);
            rd(OFS_GATE_LOW, el);
        end
        $display("random test done");
        for (int m = 0; m < 4; m++) begin
            wr(OFS_LP_CTRL, {24'h0, m[1:0], 5'h0, m[0]});
            chk({30'h0, lp_mode}, {30'h0, m[1:0]}, "mode");
            chk({31'h0, external_clock_output_off}, {31'h0, m[0]}, "clock out");
        end
        $display("low power test done");
        wr(24'h000010, 32'hFFFFFFFF);
        outs();
        rd(24'h000010, 32'h0);
        rd(24'h000013, 32'h0);
        rd(OFS_GATE_CLEAR, 32'h0);
        @(posedge clock);
        clk_en <= 1'b0;
        wr(OFS_GATE_HIGH, ~eh);
        outs();
        clk_en <= 1'b1;
        $display("reserved test done");
        test_done();
    end
    // Whole run needs well under 1500 cycles
    initial begin
        repeat (4000) @(posedge clock);
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
endmodule
